/* File: design/tos_pkg.sv */
// Purpose: constants and types for the one-shot 16-bit timer block
// Assumes: apb slave with 32-bit data, one word per register
// Notes:   offsets are byte addresses
package tos_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_OUTCTL = 8'h04;
  localparam logic [7:0] OFS_EDGE   = 8'h08;
  localparam logic [7:0] OFS_CMP0   = 8'h0C;
  localparam logic [7:0] OFS_CMP1   = 8'h10;
  localparam logic [7:0] OFS_COUNT  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // mode register: bits 3..1 select the operating mode
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 3;
  localparam logic [2:0] MODE_STOP     = 3'h0;
  localparam logic [2:0] MODE_CLR_CMP0 = 3'h6;
  localparam logic [2:0] MODE_EXT_TRIG = 3'h4;
  // output control bits
  localparam int OUT_EN_BIT   = 0;
  localparam int ONESHOT_SOFT_TRIGGER_BIT     = 6;
  localparam int OSHOT_EN_BIT = 4;
  // edge select bits of the external irq mode register
  localparam int ES_LO_BIT = 2;
  localparam int ES_HI_BIT = 3;
  // status bits
  localparam int ST_OVF_BIT  = 0;
  localparam int ST_EDGE_BIT = 1;
  localparam int ST_M0_BIT   = 2;
  localparam int ST_M1_BIT   = 3;
  localparam int ST_PULSE_BIT = 4;
  // reset values and counter step
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  // edge select encodings
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef struct packed {
    logic [15:0] cmp0;
    logic [15:0] cmp1;
  } tos_cmp_t;
endpackage

/* File: design/tos_timer.sv */
// Purpose: 16-bit timer with one-shot pulse output and capture
// Assumes: apb master keeps request stable until pready; inputs synchronous
// Notes:   zero-wait apb slave; pslverr on unmapped address
// Summary of operation
// [RL1] software keeps secondary compare below primary
// [RL2] nonzero mode bits start the counter
// [RL3] first match may shift one count clock
// [RL4] software never writes zero primary compare
// [RL5] compare below count: wrap then match
// [RL6] capture blocked during read, flag still set
// [RL7] stop timer before changing edge select
// [RL8] no software trigger during pulse
// [RL9] retrigger ignored while pulse active
// [RL10] overflow flag on max compare rollover
// [RL11] trigger clears, starts; compares drive output
// [RL12] edge select rising, falling or both
// [RL13] counter runs on until mode cleared
// [RL14] increment each tick, wrap at maximum
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tos_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trigger_input_pin,
  input  wire logic        count_tick,
  output logic             pulse_output_pin,
  output logic             primary_match_irq,
  output logic             edge_irq_request_flag
);
  logic [7:0]       mode_ff;
  logic [7:0]       outctl_ff;
  logic [7:0]       edge_ff;
  tos_pkg::tos_cmp_t cmp_ff;
  logic [15:0]      count_ff;
  logic [15:0]      nxt_count;
  logic             trig_d_ff;
  logic             pulse_ff;
  logic             ovf_ff;
  logic             edge_flag_ff;
  logic             m0_flag_ff;
  logic             m1_flag_ff;
  logic [31:0]      prdata_ff;
  logic             wr_acc;
  logic             rd_acc;
  logic             mapped;
  logic [2:0]       mode_sel;
  logic             running;
  logic             valid_edge;
  logic             ext_start;
  logic             soft_start;
  logic             start;
  logic             match0;
  logic             match1;
  logic             cap_read;
  logic             clr_status;

  function automatic logic is_wr(input logic [7:0] ofs);
    is_wr = wr_acc && (paddr == ofs);
  endfunction

  // bus decode; zero wait states keep the slave simple
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;
  assign mapped   = (paddr == tos_pkg::OFS_MODE)   ||
                    (paddr == tos_pkg::OFS_OUTCTL) ||
                    (paddr == tos_pkg::OFS_EDGE)   ||
                    (paddr == tos_pkg::OFS_CMP0)   ||
                    (paddr == tos_pkg::OFS_CMP1)   ||
                    (paddr == tos_pkg::OFS_COUNT)  ||
                    (paddr == tos_pkg::OFS_STATUS);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_ff;
  assign cap_read = psel && !pwrite && (paddr == tos_pkg::OFS_CMP1);
  assign clr_status = is_wr(tos_pkg::OFS_STATUS);

  // mode decode and trigger edge detection
  assign mode_sel = mode_ff[tos_pkg::MODE_MSB:tos_pkg::MODE_LSB];
  assign running  = (mode_sel != tos_pkg::MODE_STOP); // see [RL2] [RL13]
  always_comb begin
    valid_edge = 1'b0;
    unique case (edge_ff[tos_pkg::ES_HI_BIT:tos_pkg::ES_LO_BIT]) // see [RL12]
      tos_pkg::EDGE_FALL: valid_edge = trig_d_ff && !trigger_input_pin;
      tos_pkg::EDGE_RISE: valid_edge = !trig_d_ff && trigger_input_pin;
      tos_pkg::EDGE_BOTH: valid_edge = trig_d_ff ^ trigger_input_pin;
      default:            valid_edge = 1'b0;
    endcase
  end
  // retrigger is masked while a pulse is out
  assign ext_start = running && valid_edge && !pulse_ff &&
                     outctl_ff[tos_pkg::OSHOT_EN_BIT] &&
                     (mode_sel == tos_pkg::MODE_EXT_TRIG); // see [RL9] [RL11]
  // writing the trigger bit is a pulse, never stored
  assign soft_start = is_wr(tos_pkg::OFS_OUTCTL) &&
                      pwdata[tos_pkg::ONESHOT_SOFT_TRIGGER_BIT] && running;
  assign start  = ext_start || soft_start;
  // compare against the live count; a start lands one tick later at most
  assign match0 = running && count_tick && (count_ff == cmp_ff.cmp0); // see [RL3]
  assign match1 = running && count_tick && (count_ff == cmp_ff.cmp1);

  // trigger sample for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_d_ff <= 1'b0;
    end else begin
      trig_d_ff <= trigger_input_pin;
    end
  end

  // control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff   <= tos_pkg::RST_BYTE;
      outctl_ff <= tos_pkg::RST_BYTE;
      edge_ff   <= tos_pkg::RST_BYTE;
      cmp_ff.cmp0 <= tos_pkg::CNT_MAX;
    end else begin
      if (is_wr(tos_pkg::OFS_MODE)) begin
        mode_ff <= pwdata[7:0];
      end
      if (is_wr(tos_pkg::OFS_OUTCTL)) begin
        outctl_ff <= pwdata[7:0] & ~(8'h01 << tos_pkg::ONESHOT_SOFT_TRIGGER_BIT);
      end
      // software stops the timer first; no guard here
      if (is_wr(tos_pkg::OFS_EDGE)) begin // see [RL7]
        edge_ff <= pwdata[7:0];
      end
      if (is_wr(tos_pkg::OFS_CMP0)) begin // see [RL4]
        cmp_ff.cmp0 <= pwdata[15:0];
      end
    end
  end

  // secondary register: written by software or captured on edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_ff.cmp1 <= tos_pkg::RST_WORD;
    end else if (is_wr(tos_pkg::OFS_CMP1)) begin // see [RL1]
      cmp_ff.cmp1 <= pwdata[15:0];
    end else if (valid_edge && running && !cap_read &&
                 !outctl_ff[tos_pkg::OSHOT_EN_BIT]) begin // see [RL6]
      cmp_ff.cmp1 <= count_ff;
    end
  end

  // counter next value
  always_comb begin
    nxt_count = count_ff;
    if (!running) begin
      nxt_count = tos_pkg::RST_WORD; // see [RL13]
    end else if (start) begin
      nxt_count = tos_pkg::RST_WORD; // see [RL11]
    end else if (count_tick) begin
      if (match0 && mode_sel == tos_pkg::MODE_CLR_CMP0) begin
        nxt_count = tos_pkg::RST_WORD;
      end else begin
        // below-count compare simply waits for the wrap
        nxt_count = count_ff + tos_pkg::CNT_ONE; // see [RL5] [RL14]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= tos_pkg::RST_WORD;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // one-shot output: set on secondary match, cleared on primary match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_ff <= 1'b0;
    end else if (!running) begin
      pulse_ff <= 1'b0;
    end else if (start) begin
      pulse_ff <= 1'b1; // busy until primary match; see [RL8]
    end else if (match0) begin
      pulse_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_output_pin <= 1'b0;
    end else if (!running || !outctl_ff[tos_pkg::OUT_EN_BIT]) begin
      pulse_output_pin <= 1'b0;
    end else if (match0) begin
      pulse_output_pin <= 1'b0; // see [RL11]
    end else if (match1 && pulse_ff) begin
      pulse_output_pin <= 1'b1;
    end
  end

  // sticky status; set wins over clear-by-write-one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_ff       <= 1'b0;
      edge_flag_ff <= 1'b0;
      m0_flag_ff   <= 1'b0;
      m1_flag_ff   <= 1'b0;
    end else begin
      if (running && count_tick && count_ff == tos_pkg::CNT_MAX &&
          mode_sel == tos_pkg::MODE_CLR_CMP0 &&
          cmp_ff.cmp0 == tos_pkg::CNT_MAX) begin
        ovf_ff <= 1'b1; // see [RL10]
      end else if (clr_status && pwdata[tos_pkg::ST_OVF_BIT]) begin
        ovf_ff <= 1'b0;
      end
      if (valid_edge && running) begin
        edge_flag_ff <= 1'b1; // see [RL6]
      end else if (clr_status && pwdata[tos_pkg::ST_EDGE_BIT]) begin
        edge_flag_ff <= 1'b0;
      end
      if (match0) begin
        m0_flag_ff <= 1'b1;
      end else if (clr_status && pwdata[tos_pkg::ST_M0_BIT]) begin
        m0_flag_ff <= 1'b0;
      end
      if (match1) begin
        m1_flag_ff <= 1'b1;
      end else if (clr_status && pwdata[tos_pkg::ST_M1_BIT]) begin
        m1_flag_ff <= 1'b0;
      end
    end
  end

  // one-cycle match pulse and level edge flag outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_match_irq <= 1'b0;
    end else begin
      primary_match_irq <= match0;
    end
  end
  assign edge_irq_request_flag = edge_flag_ff;

  // read data registered in the setup cycle, shown in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      unique case (paddr)
        tos_pkg::OFS_MODE:   prdata_ff[7:0]  <= mode_ff;
        tos_pkg::OFS_OUTCTL: prdata_ff[7:0]  <= outctl_ff;
        tos_pkg::OFS_EDGE:   prdata_ff[7:0]  <= edge_ff;
        tos_pkg::OFS_CMP0:   prdata_ff[15:0] <= cmp_ff.cmp0;
        tos_pkg::OFS_CMP1:   prdata_ff[15:0] <= cmp_ff.cmp1;
        tos_pkg::OFS_COUNT:  prdata_ff[15:0] <= count_ff;
        tos_pkg::OFS_STATUS: prdata_ff[4:0]  <= {pulse_ff, m1_flag_ff,
                                 m0_flag_ff, edge_flag_ff, ovf_ff};
        default:             prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  property p_stop_clears;
    @(posedge pclk) disable iff (!presetn)
    !running |=> (count_ff == 16'h0000) && !pulse_output_pin;
  endproperty
  a_stop_clears: assert property (p_stop_clears) // see [RL2]
    else $error("count not cleared while stopped");

  property p_tick_inc;
    @(posedge pclk) disable iff (!presetn)
    running && count_tick && !start && !match0
      |=> count_ff == $past(count_ff) + 16'h0001;
  endproperty
  a_tick_inc: assert property (p_tick_inc) // see [RL14]
    else $error("counter did not advance");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    running && count_tick && !start && count_ff == 16'hFFFF && !match0
      |=> count_ff == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) // see [RL5]
    else $error("counter did not wrap");

  property p_ovf;
    @(posedge pclk) disable iff (!presetn)
    running && count_tick && count_ff == 16'hFFFF &&
    mode_sel == 3'h6 && cmp_ff.cmp0 == 16'hFFFF |=> ovf_ff;
  endproperty
  a_ovf: assert property (p_ovf) // see [RL10]
    else $error("overflow flag not set");

  property p_retrig;
    @(posedge pclk) disable iff (!presetn)
    pulse_ff && valid_edge && !soft_start && running
      |=> count_ff != 16'h0000 || $past(count_ff) == 16'hFFFF ||
          $past(match0);
  endproperty
  a_retrig: assert property (p_retrig) // see [RL9]
    else $error("retrigger restarted counter");

  property p_cap_hold;
    @(posedge pclk) disable iff (!presetn)
    cap_read && valid_edge && !wr_acc |=> $stable(cmp_ff.cmp1) && edge_flag_ff;
  endproperty
  a_cap_hold: assert property (p_cap_hold) // see [RL6]
    else $error("capture during read");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    ext_start |=> count_ff == 16'h0000 && pulse_ff;
  endproperty
  a_start: assert property (p_start) // see [RL11]
    else $error("trigger did not clear and start");

  property p_out_off;
    @(posedge pclk) disable iff (!presetn)
    match0 |=> !pulse_output_pin ##1 !primary_match_irq || match0;
  endproperty
  a_out_off: assert property (p_out_off) // see [RL11]
    else $error("output not cleared on primary match");

  property p_edge_sel;
    @(posedge pclk) disable iff (!presetn)
    running && edge_ff[3:2] == 2'h1 && trig_d_ff && !trigger_input_pin
      |-> !valid_edge;
  endproperty
  a_edge_sel: assert property (p_edge_sel) // see [RL12]
    else $error("falling edge taken in rising mode");
endmodule
`default_nettype wire

/* File: tb/tos_pin_model.sv */
// Purpose: far-side model of the trigger pin and the pulse output pin
// Assumes: one pclk domain; fire is a one-cycle request from the bench
// Notes:   width holds the high time, in pclk cycles, of the last pulse
`timescale 1ns/1ps
`default_nettype none
module tos_pin_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,
  input  wire logic        lvl,
  input  wire logic        pulse_output_pin,
  output logic             trigger_input_pin,
  output logic [7:0]       pulses,
  output logic [15:0]      width
);
  logic seen_ff;

  // the pin moves only on request, so every edge is one the bench chose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_input_pin <= 1'b0;
    end else if (fire) begin
      trigger_input_pin <= lvl;
    end
  end

  // count output pulses and time the high phase of each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_ff <= 1'b0;
      pulses  <= 8'h00;
      width   <= 16'h0000;
    end else begin
      seen_ff <= pulse_output_pin;
      if (pulse_output_pin && !seen_ff) begin
        pulses <= pulses + 8'h01;
        width  <= 16'h0001;
      end else if (pulse_output_pin) begin
        width <= width + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tos_timer_test.sv */
// Purpose: self-checking bench for the one-shot 16-bit timer
// Assumes: zero-wait apb slave; count_tick high every cycle
// Notes:   register rows first, then one-shot, capture, overflow, reset
`timescale 1ns/1ps
`default_nettype none
module tos_timer_test;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [15:0] d;
    logic        err;
  } tos_row_t;
  localparam logic [15:0] OC = (16'h0001 << tos_pkg::OUT_EN_BIT) |
                               (16'h0001 << tos_pkg::OSHOT_EN_BIT);
  localparam logic [15:0] M_EXT = 16'(tos_pkg::MODE_EXT_TRIG) << 1;
  localparam logic [15:0] M_CLR = 16'(tos_pkg::MODE_CLR_CMP0) << 1;
  logic        pclk, presetn, psel, penable, pwrite, fire, lvl, tick;
  logic        pready, pslverr, pout, mirq, eflag, trg, e;
  logic [7:0]  paddr, pulses, p0;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] width, c0;
  logic [1:0]  kinds[3];
  int          fail_count, num_checks, n;
  int          cyc = 0;
  tos_row_t    rows[13];

  tos_timer i_tos_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_input_pin(trg), .count_tick(tick),
    .pulse_output_pin(pout), .primary_match_irq(mirq),
    .edge_irq_request_flag(eflag));
  tos_pin_model i_tos_pin_model (.pclk(pclk), .presetn(presetn),
    .fire(fire), .lvl(lvl), .pulse_output_pin(pout),
    .trigger_input_pin(trg), .pulses(pulses), .width(width));

  // clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // watchdog; the overflow run alone needs some 65.5k cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count = fail_count + 1;
      $display("ERROR t=%0t timeout", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    num_checks = num_checks + 1;
    if (ok !== 1'b1) begin
      fail_count = fail_count + 1;
      $display("ERROR t=%0t %s", $time, m);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n = n + 1;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // ask the model for one edge on the trigger pin
  task automatic toggle_trg();
    @(posedge pclk);
    fire <= 1'b1;
    lvl  <= ~trg;
    @(posedge pclk);
    fire <= 1'b0;
  endtask

  // main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fire = 1'b0;
    lvl = 1'b0;
    tick = 1'b1;
    presetn = 1'b0;
    fail_count = 0;
    num_checks = 0;
    kinds = '{tos_pkg::EDGE_RISE, tos_pkg::EDGE_FALL, tos_pkg::EDGE_BOTH};
    rows = '{'{1'b0, tos_pkg::OFS_MODE, 16'h0000, 1'b0},
      '{1'b0, tos_pkg::OFS_CMP0, 16'hFFFF, 1'b0},
      '{1'b0, tos_pkg::OFS_CMP1, 16'h0000, 1'b0},
      '{1'b0, tos_pkg::OFS_COUNT, 16'h0000, 1'b0},
      '{1'b0, tos_pkg::OFS_STATUS, 16'h0000, 1'b0},
      '{1'b0, 8'h1C, 16'h0000, 1'b1},
      '{1'b1, 8'h1C, 16'hFFFF, 1'b1},
      '{1'b1, tos_pkg::OFS_CMP1, 16'h0004, 1'b0},
      '{1'b1, tos_pkg::OFS_CMP0, 16'h000A, 1'b0},
      '{1'b0, tos_pkg::OFS_CMP0, 16'h000A, 1'b0},
      '{1'b1, tos_pkg::OFS_COUNT, 16'h1234, 1'b0},
      '{1'b0, tos_pkg::OFS_COUNT, 16'h0000, 1'b0},
      '{1'b0, tos_pkg::OFS_CMP1, 16'h0004, 1'b0}};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk(e === rows[i].err, "pslverr");
      if (!rows[i].wr) chk(r === {16'h0000, rows[i].d}, "read value");
    end
    $display("test done: register rows");
    // external one-shot for every edge kind, with a retrigger mid-pulse
    foreach (kinds[k]) begin
      apb(1'b1, tos_pkg::OFS_MODE, 16'h0000);
      apb(1'b1, tos_pkg::OFS_EDGE, 16'(kinds[k]) << 2);
      if ((kinds[k] == tos_pkg::EDGE_RISE) == trg) toggle_trg();
      apb(1'b1, tos_pkg::OFS_OUTCTL, OC);
      apb(1'b1, tos_pkg::OFS_MODE, M_EXT);
      p0 = pulses;
      toggle_trg();
      repeat (3) @(posedge pclk);
      repeat (2) toggle_trg();
      repeat (20) @(posedge pclk);
      chk(pulses === p0 + 8'h01, "pulse count");
      chk(width === 16'h0006, "pulse width");
      apb(1'b0, tos_pkg::OFS_COUNT, 16'h0000);
      c0 = r[15:0];
      apb(1'b0, tos_pkg::OFS_COUNT, 16'h0000);
      chk((r[15:0] > c0) === 1'b1, "count stalled");
      $display("test done: one-shot edge kind %0d", k);
    end
    // software trigger only after the previous pulse has ended
    p0 = pulses;
    apb(1'b1, tos_pkg::OFS_OUTCTL, OC | 16'h0040);
    repeat (20) @(posedge pclk);
    chk(pulses === p0 + 8'h01, "soft pulse count");
    chk(width === 16'h0006, "soft pulse width");
    $display("test done: soft trigger");
    // capture must not land while the capture register is being read
    apb(1'b1, tos_pkg::OFS_OUTCTL, 16'h0000);
    apb(1'b1, tos_pkg::OFS_CMP0, 16'h0100);
    apb(1'b1, tos_pkg::OFS_MODE, M_CLR);
    apb(1'b1, tos_pkg::OFS_STATUS, 16'h000F);
    // the clear lands on the edge just taken; look once it has settled
    @(negedge pclk);
    chk(eflag === 1'b0, "edge flag not cleared");
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= 1'b0;
    paddr   <= tos_pkg::OFS_CMP1;
    penable <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      @(posedge pclk);
      penable <= ~penable;
      fire    <= (i == 1);
      lvl     <= ~trg;
    end
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(eflag === 1'b1, "edge flag missing");
    apb(1'b0, tos_pkg::OFS_CMP1, 16'h0000);
    chk(r === 32'h0000_0004, "capture during read");
    toggle_trg();
    repeat (4) @(posedge pclk);
    apb(1'b0, tos_pkg::OFS_CMP1, 16'h0000);
    chk(r[15:0] !== 16'h0004, "no capture");
    $display("test done: capture retention");
    // compare lowered below the count: no match before the wrap
    apb(1'b1, tos_pkg::OFS_MODE, 16'h0000);
    apb(1'b1, tos_pkg::OFS_MODE, M_CLR);
    repeat (128) @(posedge pclk);
    apb(1'b1, tos_pkg::OFS_CMP0, 16'h0020);
    p0 = 8'h00;
    repeat (300) begin
      @(posedge pclk);
      if (mirq === 1'b1) p0 = 8'h01;
    end
    chk(p0 === 8'h00, "early match");
    apb(1'b0, tos_pkg::OFS_COUNT, 16'h0000);
    chk((r[15:0] > 16'h0100) === 1'b1, "count cleared");
    // maximum compare: rollover sets the overflow flag
    apb(1'b1, tos_pkg::OFS_CMP0, 16'hFFFF);
    n = 0;
    do begin
      @(posedge pclk);
      n = n + 1;
    end while (mirq !== 1'b1 && n < 70000);
    chk(mirq === 1'b1, "no match at maximum");
    apb(1'b0, tos_pkg::OFS_STATUS, 16'h0000);
    chk(r[tos_pkg::ST_OVF_BIT] === 1'b1, "overflow flag");
    apb(1'b1, tos_pkg::OFS_STATUS, 16'h0001);
    apb(1'b0, tos_pkg::OFS_STATUS, 16'h0000);
    chk(r[tos_pkg::ST_OVF_BIT] === 1'b0, "overflow not cleared");
    $display("test done: compare change and overflow");
    // reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(pout === 1'b0, "pulse pin after reset");
    apb(1'b0, tos_pkg::OFS_MODE, 16'h0000);
    chk(r === 32'h0000_0000, "mode after reset");
    apb(1'b0, tos_pkg::OFS_CMP0, 16'h0000);
    chk(r === 32'h0000_FFFF, "compare after reset");
    $display("test done: reset");
    print_verdict();
  end
endmodule
`default_nettype wire
